// *** src/dspo_map.vh ***
`ifndef DSPO_MAP_VH
`define DSPO_MAP_VH
// Path-control word fields
`define DSPO_PC_QZERO      14
`define DSPO_PC_SRC_LO     18
`define DSPO_PC_SRC_HI     19
// Discriminator config fields
`define DSPO_DC_DELAY_LO   0
`define DSPO_DC_DELAY_HI   2
`define DSPO_DC_TAPS_LO    3
`define DSPO_DC_TAPS_HI    8
`define DSPO_DC_ASYM       9
`define DSPO_DC_ODD        10
`define DSPO_DC_DEC_LO     11
`define DSPO_DC_DEC_HI     13
`define DSPO_DC_ENABLE     14
`define DSPO_DC_PMUL_LO    15
`define DSPO_DC_PMUL_HI    16
// Output control fields
`define DSPO_OC_BSEL_LO    20
`define DSPO_OC_BSEL_HI    21
`define DSPO_OC_ASEL_LO    22
`define DSPO_OC_ASEL_HI    23
`define DSPO_OC_NOTPAR     25
// Encodings
`define DSPO_SRC_PHASE     2'h0
`define DSPO_SRC_MAG       2'h1
`define DSPO_ASEL_I        2'h0
`define DSPO_ASEL_MAG      2'h1
`define DSPO_BSEL_Q        2'h0
`define DSPO_BSEL_PHASE    2'h1
`define DSPO_MAX_DELAY     8
`define DSPO_MAX_TAPS_SYM  63
`define DSPO_MAX_TAPS_ASYM 32
`define DSPO_TAPS_CLAMP    6'h20
`endif

// *** src/dspo_phase_delay.v ***
`timescale 1ns/100ps
// Phase history line; read data registered
module dspo_phase_delay #(
  parameter WIDTH = 18,
  parameter DEPTH = 8
) (
  input  wire             sys_clk,
  input  wire             reset,
  input  wire             shiftEn,
  input  wire [WIDTH-1:0] dataIn,
  input  wire [2:0]       tapSel,
  output reg  [WIDTH-1:0] dataOut
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer k;

  always @(posedge sys_clk) begin
    if (reset) begin
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem[k] <= {WIDTH{1'b0}};
      end
    end else if (shiftEn) begin
      mem[0] <= dataIn;
      for (k = 1; k < DEPTH; k = k + 1) begin
        mem[k] <= mem[k-1];
      end
    end
  end

  // Read on the shift edge, before it lands: mem[D-1] is then D samples
  // back, and the tap holds steady until the next sample arrives
  always @(posedge sys_clk) begin
    if (reset) begin
      dataOut <= {WIDTH{1'b0}};
    end else if (shiftEn) begin
      dataOut <= mem[tapSel];
    end
  end
endmodule

// *** src/dspo_discriminator_out.v ***
`timescale 1ns/100ps
`include "dspo_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Source field 00 phase difference, 01 magnitude, 1X resampler I.
// - Magnitude or resampler I source bypasses shift, delay and subtract.
// - All three filter input candidates are 18 bits.
// - Path bit 14 set zeroes converter Q; clear passes I and Q.
// - Phase and magnitude sources load on converter data-ready.
// - Converter enabled by AGC ready, or resampler ready when resampler on.
// - Config bits 15-16 multiply phase by 1, 2, 4, 8 modulo 2 pi.
// - Config bit 14 enables the discriminator.
// - Config bits 11-13 set filter decimation.
// - Bit 10 odd/even symmetry; bit 9 symmetric or asymmetric.
// - Config bits 3-8 set filter tap count.
// - Config bits 0-2 set the delay count.
// - Two 16-bit words; A source bits 22-23, B source bits 20-21.
// - Parallel mode active when output bit 25 is zero.
// - Upper bytes of both words always carry parallel data.
// - Strobe in first cycle of each new A word sample.
// - I/Q/mag/phase change at symbol rate; frequency at filter output rate.
// - Mag and phase one sample after I/Q; I and Q aligned.
// - Frequency strobe at decimated filter rate, lagging I/Q.
// - Frequency is phase minus phase D samples back, D from 1 to 8.
// - Filter holds up to 63 symmetric or 32 asymmetric taps.
module dspo_discriminator_out #(
  parameter DW = 18,
  parameter OW = 16
) (
  // Clock and reset
  input  wire          sys_clk,
  input  wire          reset,
  // Control words
  input  wire [31:0]   pathControl,
  input  wire [31:0]   discriminatorConfig,
  input  wire [31:0]   outputControl,
  input  wire          resamplerOn,
  // Upstream samples and strobes
  input  wire          agcReady,
  input  wire          resamplerReady,
  input  wire [DW-1:0] iIn,
  input  wire [DW-1:0] qIn,
  input  wire [DW-1:0] resamplerI,
  // Converter results
  input  wire          convReady,
  input  wire [DW-1:0] convMag,
  input  wire [DW-1:0] convPhase,
  // Filter results
  input  wire          firReady,
  input  wire [DW-1:0] firOut,
  // To converter
  output reg           convLoad,
  output reg  [DW-1:0] convI,
  output reg  [DW-1:0] convQ,
  // To filter
  output reg           firLoad,
  output reg  [DW-1:0] firIn,
  output reg           firEnable,
  output reg  [2:0]    firDecimation,
  output reg           firOddSym,
  output reg           firAsym,
  output reg  [5:0]    firTaps,
  // Parallel port
  output reg  [OW-1:0] resultWordA,
  output reg  [OW-1:0] resultWordB,
  output reg           outputStrobe_n,
  output reg           parallelActive
);
  ////////////////////////////////////////////////////////////////////////////
  // Path-control fields
  wire [1:0] srcSel   = pathControl[`DSPO_PC_SRC_HI:`DSPO_PC_SRC_LO];
  wire       qZero    = pathControl[`DSPO_PC_QZERO];
  wire       phaseSrc = (srcSel == `DSPO_SRC_PHASE);

  // Discriminator config fields
  wire [2:0] delaySel = discriminatorConfig[`DSPO_DC_DELAY_HI:`DSPO_DC_DELAY_LO];
  wire [1:0] pmul     = discriminatorConfig[`DSPO_DC_PMUL_HI:`DSPO_DC_PMUL_LO];
  wire       discOn   = discriminatorConfig[`DSPO_DC_ENABLE];
  wire [5:0] tapsReq  = discriminatorConfig[`DSPO_DC_TAPS_HI:`DSPO_DC_TAPS_LO];
  wire       asymReq  = discriminatorConfig[`DSPO_DC_ASYM];

  // Output control fields
  wire [1:0] aSel     = outputControl[`DSPO_OC_ASEL_HI:`DSPO_OC_ASEL_LO];
  wire [1:0] bSel     = outputControl[`DSPO_OC_BSEL_HI:`DSPO_OC_BSEL_LO];
  wire       parMode  = ~outputControl[`DSPO_OC_NOTPAR];

  ////////////////////////////////////////////////////////////////////////////
  // Converter input gating
  wire convEnable = resamplerOn ? resamplerReady : agcReady;

  always @(posedge sys_clk) begin
    if (reset) begin
      convLoad <= 1'b0;
      convI    <= {DW{1'b0}};
      convQ    <= {DW{1'b0}};
    end else begin
      convLoad <= convEnable;
      if (convEnable) begin
        convI <= iIn;
        convQ <= qZero ? {DW{1'b0}} : qIn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase multiply is a left shift; modulo 2 pi falls out of wrap
  reg [DW-1:0] phaseShifted;
  always @* begin
    phaseShifted = convPhase << pmul;
  end

  wire [DW-1:0] phaseDelayed;
  reg           histShift;
  reg [DW-1:0]  curPhase;

  dspo_phase_delay #(
    .WIDTH (DW),
    .DEPTH (`DSPO_MAX_DELAY)
  ) uDelay (
    .sys_clk (sys_clk),
    .reset   (reset),
    .shiftEn (histShift),
    .dataIn  (curPhase),
    .tapSel  (delaySel),
    .dataOut (phaseDelayed)
  );

  // Pipeline, counted from the edge that samples convReady:
  //   +1 curPhase holds the multiplied sample
  //   +2 history shifts, tap read of D samples back
  //   +3 difference valid
  //   +4 firLoad and firIn
  // Samples closer than three cycles overwrite curPhase mid-flight.
  // History freezes on other sources, so it refills after a switch.
  reg diffPending;
  reg diffValid;
  always @(posedge sys_clk) begin
    if (reset) begin
      curPhase    <= {DW{1'b0}};
      histShift   <= 1'b0;
      diffPending <= 1'b0;
      diffValid   <= 1'b0;
    end else begin
      histShift   <= convReady & phaseSrc;
      diffPending <= histShift;
      diffValid   <= diffPending;
      if (convReady) begin
        curPhase <= phaseShifted;
      end
    end
  end

  // Tap holds the sample D back from the shift until the next sample
  wire [DW-1:0] phaseDiff = curPhase - phaseDelayed;

  ////////////////////////////////////////////////////////////////////////////
  // Filter input select
  always @(posedge sys_clk) begin
    if (reset) begin
      firLoad <= 1'b0;
      firIn   <= {DW{1'b0}};
    end else begin
      firLoad <= 1'b0;
      if (srcSel == `DSPO_SRC_PHASE) begin
        if (diffValid) begin
          firLoad <= discOn;
          firIn   <= phaseDiff;
        end
      end else if (srcSel == `DSPO_SRC_MAG) begin
        if (convReady) begin
          firLoad <= discOn;
          firIn   <= convMag;
        end
      end else begin
        if (resamplerReady) begin
          firLoad <= discOn;
          firIn   <= resamplerI;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filter parameters, taps clamped to what the structure holds
  always @(posedge sys_clk) begin
    if (reset) begin
      firEnable     <= 1'b0;
      firDecimation <= 3'h0;
      firOddSym     <= 1'b0;
      firAsym       <= 1'b0;
      firTaps       <= 6'h00;
    end else begin
      firEnable     <= discOn;
      firDecimation <= discriminatorConfig[`DSPO_DC_DEC_HI:`DSPO_DC_DEC_LO];
      firOddSym     <= discriminatorConfig[`DSPO_DC_ODD];
      firAsym       <= asymReq;
      if (asymReq && tapsReq > `DSPO_TAPS_CLAMP) begin
        firTaps <= `DSPO_TAPS_CLAMP;
      end else begin
        firTaps <= tapsReq;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel output; mag/phase follow converter ready, one sample after I/Q
  reg           aUpdate;
  reg           bUpdate;
  reg [OW-1:0]  aNext;
  reg [OW-1:0]  bNext;

  always @* begin
    aUpdate = 1'b0;
    aNext   = resultWordA;
    if (aSel == `DSPO_ASEL_I) begin
      aUpdate = convEnable;
      aNext   = iIn[DW-1:DW-OW];
    end else if (aSel == `DSPO_ASEL_MAG) begin
      aUpdate = convReady;
      aNext   = convMag[DW-1:DW-OW];
    end else begin
      aUpdate = firReady;
      aNext   = firOut[DW-1:DW-OW];
    end
    bUpdate = 1'b0;
    bNext   = resultWordB;
    if (bSel == `DSPO_BSEL_Q) begin
      bUpdate = convEnable;
      bNext   = qIn[DW-1:DW-OW];
    end else if (bSel == `DSPO_BSEL_PHASE) begin
      bUpdate = convReady;
      bNext   = convPhase[DW-1:DW-OW];
    end else begin
      bUpdate = convReady;
      bNext   = convMag[DW-1:DW-OW];
    end
  end

  // Upper bytes always update; low bytes only in parallel mode so that
  // other output modes may reuse them without disturbing the strobe.
  always @(posedge sys_clk) begin
    if (reset) begin
      resultWordA    <= {OW{1'b0}};
      resultWordB    <= {OW{1'b0}};
      outputStrobe_n <= 1'b1;
      parallelActive <= 1'b0;
    end else begin
      parallelActive <= parMode;
      outputStrobe_n <= ~aUpdate;
      if (aUpdate) begin
        resultWordA[OW-1:OW/2] <= aNext[OW-1:OW/2];
        if (parMode) begin
          resultWordA[OW/2-1:0] <= aNext[OW/2-1:0];
        end
      end
      if (bUpdate) begin
        resultWordB[OW-1:OW/2] <= bNext[OW-1:OW/2];
        if (parMode) begin
          resultWordB[OW/2-1:0] <= bNext[OW/2-1:0];
        end
      end
    end
  end
endmodule

// *** verif/dspo_disc_monitor.sv ***
`timescale 1ns/100ps
////////////////////////////////
module dspo_disc_monitor (
  // Clock and reset
  input wire        sys_clk,
  input wire        reset,
  // Controls and samples
  input wire [31:0] pathControl,
  input wire [31:0] discriminatorConfig,
  input wire [31:0] outputControl,
  input wire        resamplerOn,
  input wire        agcReady,
  input wire        resamplerReady,
  input wire        convReady,
  input wire [17:0] iIn,
  input wire [17:0] resamplerI,
  input wire [17:0] convMag,
  // Results
  input wire        convLoad,
  input wire [17:0] convI,
  input wire [17:0] convQ,
  input wire        firLoad,
  input wire [17:0] firIn,
  input wire        firAsym,
  input wire [5:0]  firTaps,
  input wire [15:0] resultWordA,
  input wire        outputStrobe_n,
  input wire        parallelActive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_magIn;
    convReady && outputControl[23:22] == 2'h1 && !outputControl[25];
  endsequence
  sequence s_newA;
    !outputStrobe_n ##1 outputStrobe_n;
  endsequence
  property p_strobeA;
    s_magIn ##1 !convReady |-> s_newA;
  endproperty
  a_strobeA: assert property (p_strobeA)
    else $error("strobe not a single cycle after A sample");
  property p_magWord;
    s_magIn |=> resultWordA == $past(convMag[17:2]);
  endproperty
  a_magWord: assert property (p_magWord)
    else $error("word A not magnitude");
  property p_upper;
    convReady && outputControl[23:22] == 2'h1 |=> resultWordA[15:8] == $past(convMag[17:10]);
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper byte of word A stale");
  property p_qZero;
    agcReady && !resamplerOn && pathControl[14] |=> convLoad && convQ == 18'h0
      && convI == $past(iIn);
  endproperty
  a_qZero: assert property (p_qZero)
    else $error("converter Q not zeroed");
  property p_resEn;
    resamplerReady && !agcReady |=> convLoad == $past(resamplerOn);
  endproperty
  a_resEn: assert property (p_resEn)
    else $error("converter enable wrong source");
  property p_firMag;
    convReady && pathControl[19:18] == 2'h1 && discriminatorConfig[14]
      |=> firLoad && firIn == $past(convMag);
  endproperty
  a_firMag: assert property (p_firMag)
    else $error("filter input not magnitude");
  property p_firRes;
    resamplerReady && pathControl[19] && discriminatorConfig[14]
      |=> firLoad && firIn == $past(resamplerI);
  endproperty
  a_firRes: assert property (p_firRes)
    else $error("filter input not resampler I");
  property p_firOff;
    !discriminatorConfig[14] [*5] |-> !firLoad;
  endproperty
  a_firOff: assert property (p_firOff)
    else $error("filter loaded while disabled");
  property p_par;
    outputControl[25] ##1 outputControl[25] |-> !parallelActive;
  endproperty
  a_par: assert property (p_par)
    else $error("parallel mode while bit 25 set");
  property p_taps;
    !discriminatorConfig[9] |=> firTaps == $past(discriminatorConfig[8:3]) && !firAsym;
  endproperty
  a_taps: assert property (p_taps)
    else $error("tap count not taken");
endmodule

bind dspo_discriminator_out dspo_disc_monitor mon (
  .sys_clk(sys_clk), .reset(reset), .pathControl(pathControl),
  .discriminatorConfig(discriminatorConfig), .outputControl(outputControl),
  .resamplerOn(resamplerOn), .agcReady(agcReady), .resamplerReady(resamplerReady),
  .convReady(convReady), .iIn(iIn), .resamplerI(resamplerI), .convMag(convMag),
  .convLoad(convLoad), .convI(convI), .convQ(convQ), .firLoad(firLoad),
  .firIn(firIn), .firAsym(firAsym), .firTaps(firTaps), .resultWordA(resultWordA),
  .outputStrobe_n(outputStrobe_n), .parallelActive(parallelActive)
);

// *** verif/dspo_dsp_model.sv ***
`timescale 1ns/100ps
////////////////////////////////
module dspo_dsp_model (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset,
  // Parallel port
  input  wire [15:0] resultWordA,
  input  wire        outputStrobe_n,
  // Captured
  output reg  [15:0] lastA,
  output reg  [7:0]  wordCount
);
  // Takes A only: B has no promise of alignment with the strobe
  always @(posedge sys_clk) begin
    if (reset) begin
      lastA     <= 16'h0;
      wordCount <= 8'h0;
    end else if (!outputStrobe_n) begin
      lastA     <= resultWordA;
      wordCount <= wordCount + 8'h1;
    end
  end
endmodule

// *** verif/dspo_discriminator_out_tb.sv ***
`timescale 1ns/100ps
module dspo_discriminator_out_tb;
  reg         sys_clk = 1'h0;
  reg         reset = 1'h1;
  reg  [31:0] pathControl = 32'h0;
  reg  [31:0] discriminatorConfig = 32'h0;
  reg  [31:0] outputControl = 32'h0;
  reg         resamplerOn = 1'h0;
  reg         agcReady = 1'h0;
  reg         resamplerReady = 1'h0;
  reg         convReady = 1'h0;
  reg         firReady = 1'h0;
  reg  [17:0] iIn = 18'h0;
  reg  [17:0] qIn = 18'h0;
  reg  [17:0] resamplerI = 18'h0;
  reg  [17:0] convMag = 18'h0;
  reg  [17:0] convPhase = 18'h0;
  reg  [17:0] firOut = 18'h0;
  reg  [17:0] v;
  wire        convLoad, firLoad, firEnable, firOddSym, firAsym;
  wire        outputStrobe_n, parallelActive;
  wire [17:0] convI, convQ, firIn;
  wire [2:0]  firDecimation;
  wire [5:0]  firTaps;
  wire [15:0] resultWordA, resultWordB, lastA;
  wire [7:0]  wordCount;
  integer     failCount = 0;
  integer     checksDone = 0;
  integer     c, k, i, base;

  always #2 sys_clk = ~sys_clk;

  dspo_discriminator_out dspo_discriminator_out_inst (
    .sys_clk(sys_clk), .reset(reset), .pathControl(pathControl),
    .discriminatorConfig(discriminatorConfig), .outputControl(outputControl),
    .resamplerOn(resamplerOn), .agcReady(agcReady), .resamplerReady(resamplerReady),
    .iIn(iIn), .qIn(qIn), .resamplerI(resamplerI), .convReady(convReady),
    .convMag(convMag), .convPhase(convPhase), .firReady(firReady), .firOut(firOut),
    .convLoad(convLoad), .convI(convI), .convQ(convQ), .firLoad(firLoad),
    .firIn(firIn), .firEnable(firEnable), .firDecimation(firDecimation),
    .firOddSym(firOddSym), .firAsym(firAsym), .firTaps(firTaps),
    .resultWordA(resultWordA), .resultWordB(resultWordB),
    .outputStrobe_n(outputStrobe_n), .parallelActive(parallelActive)
  );
  dspo_dsp_model dspo_dsp_model_inst (
    .sys_clk(sys_clk), .reset(reset), .resultWordA(resultWordA),
    .outputStrobe_n(outputStrobe_n), .lastA(lastA), .wordCount(wordCount)
  );
  ////////////////////////////////
  task testDone;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string what, input [17:0] e, input [17:0] g);
    checksDone = checksDone + 1;
    if (g !== e) begin
      failCount = failCount + 1;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task chkBit(input string what, input e, input g);
    chk(what, {17'h0, e}, {17'h0, g});
  endtask
  task cfg(input [31:0] pc, input [31:0] dc, input [31:0] oc, input ro);
    @(posedge sys_clk);
    pathControl <= pc;
    discriminatorConfig <= dc;
    outputControl <= oc;
    resamplerOn <= ro;
  endtask
  // Kind 0 AGC, 1 resampler, 2 converter, 3 filter; phase carries ~val
  task pulse(input [1:0] kind, input [17:0] val);
    @(posedge sys_clk);
    {iIn, qIn, resamplerI, convMag, firOut} <= {5{val}};
    convPhase <= ~val;
    {agcReady, resamplerReady, convReady, firReady} <= 4'h8 >> kind;
    @(posedge sys_clk);
    {agcReady, resamplerReady, convReady, firReady} <= 4'h0;
    #1;
  endtask
  // Phase path answers four cycles late; the bound leaves room
  task waitFir;
    for (i = 0; i < 8 && firLoad !== 1'h1; i = i + 1)
      @(posedge sys_clk) #1;
    if (firLoad !== 1'h1) begin
      $display("unexpected firLoad expected 1 seen %b", firLoad);
      failCount = failCount + 1;
      testDone;
    end
  endtask
  ////////////////////////////////
  task tConv;
    cfg(32'h4000, 32'h0, 32'h0, 1'h0);
    pulse(2'h0, 18'h2a5a5);
    chkBit("convLoad", 1'h1, convLoad);
    chk("convQ", 18'h0, convQ);
    cfg(32'h0, 32'h0, 32'h0, 1'h1);
    pulse(2'h0, 18'h1234);
    chkBit("convLoad", 1'h0, convLoad);
    pulse(2'h1, 18'h1234);
    chk("convQ", 18'h1234, convQ);
  endtask
  task tOut;
    @(posedge sys_clk) #1;
    base = wordCount;
    for (c = 0; c < 4; c = c + 1) begin
      cfg(32'h0, 32'h0, {8'h0, c[1:0], c[1:0], 20'h0}, 1'h0);
      v = 18'h3c3c3 + c[17:0];
      k = (c == 0) ? 0 : (c == 1) ? 2 : 3;
      pulse(k[1:0], v);
      chk("wordA", {2'h0, v[17:2]}, {2'h0, resultWordA});
      chkBit("strobe_n", 1'h0, outputStrobe_n);
      if (c < 2) begin
        chk("wordB", {2'h0, c == 0 ? v[17:2] : ~v[17:2]}, {2'h0, resultWordB});
      end else begin
        pulse(2'h2, ~v);
        chk("wordB", {2'h0, ~v[17:2]}, {2'h0, resultWordB});
        chkBit("strobe_n", 1'h1, outputStrobe_n);
      end
      @(posedge sys_clk) #1;
      chkBit("strobe_n", 1'h1, outputStrobe_n);
    end
    chk("count", 18'h4, wordCount - base[7:0]);
    chk("lastA", {2'h0, v[17:2]}, {2'h0, lastA});
  endtask
  task tFrozen;
    cfg(32'h0, 32'h0, 32'h400000, 1'h0);
    pulse(2'h2, 18'h3ffff);
    chkBit("parallel", 1'h1, parallelActive);
    cfg(32'h0, 32'h0, 32'h2400000, 1'h0);
    pulse(2'h2, 18'h0);
    chk("wordA", 18'hff, {2'h0, resultWordA});
    chkBit("parallel", 1'h0, parallelActive);
  endtask
  task tFir;
    cfg(32'h40000, 32'h5cb5, 32'h0, 1'h0);
    pulse(2'h2, 18'h15555);
    chk("firIn", 18'h15555, firIn);
    chk("taps", 18'h16, {12'h0, firTaps});
    chk("decim", 18'h3, {15'h0, firDecimation});
    chkBit("odd", 1'h1, firOddSym);
    chkBit("enable", 1'h1, firEnable);
    cfg(32'h80000, 32'h4340, 32'h0, 1'h0);
    pulse(2'h1, 18'h2aaaa);
    chk("firIn", 18'h2aaaa, firIn);
    chk("taps", 18'h20, {12'h0, firTaps});
    cfg(32'h80000, 32'h0, 32'h0, 1'h0);
    pulse(2'h1, 18'h1);
    chkBit("firLoad", 1'h0, firLoad);
  endtask
  // Multiplier for CW, BPSK, QPSK, 8PSK with delay D = code + 1
  task tPhase;
    for (c = 0; c < 4; c = c + 1) begin
      cfg(32'h0, {15'h0, c[1:0], 12'h800, c[2:0]}, 32'h0, 1'h0);
      for (k = 0; k < c + 2; k = k + 1) begin
        pulse(2'h2, ~(k[17:0] << 8));
        waitFir;
      end
      v = (c[17:0] + 18'h1) << (8 + c);
      chk("freq", v, firIn);
    end
  endtask
  ////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'h0;
    @(posedge sys_clk) #1;
    chkBit("strobe_n", 1'h1, outputStrobe_n);
    tConv;
    tOut;
    tFrozen;
    tFir;
    tPhase;
    testDone;
  end
endmodule
